// ---- hdl/vco_subsystem_control_regs.sv ----
// vco subsystem control register bank with auxiliary output control
// assumes a register port driven by logic on sys_clk, chip enable from a pin
//
// Functional notes
// RL1: bit 0 picks serial port or static outputs
// RL2: static mode drives pins from bits 3:1
// RL3: bit 4 selects 1.8 V or 3.3 V
// RL4: chip enable triggers phase sync in exact mode
// RL5: bits 11:10 route status to one pin
// RL6: bits 13:12 set disabled output drive state
// RL7: bit 0 enables manual calibration
// RL8: sub-band bits 8:6, capacitor bits 5:1
// RL9: bit 9 enables manual tuning
// RL10: bit 16 enables charge pump auto-scaling
// RL11: divide ratio mute, fundamental, even, rounded down
// RL12: first buffer gain, 3 dB steps
// RL13: second buffer gain, same encoding
// RL14: divider stage gain, max or minus 3 dB
// RL15: seed sets output phase at sync
// RL16: host writes reserved bits with reset values
`timescale 1ns/1ps
module vco_subsystem_control_regs (
   // clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // register port
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [5:0] reg_addr,
   input wire logic [23:0] reg_wdata,
   output logic [23:0] reg_rdata,
   output logic reg_rvalid,
   // device context
   input wire logic chip_en_pin,
   input wire logic exact_freq_mode,
   input wire logic [23:0] phase_seed,
   input wire logic status_in,
   input wire logic aux_enable,
   input wire logic [2:0] aux_serial_bits,
   // auxiliary pins
   output logic [2:0] aux_out,
   output logic [2:0] aux_oe_n,
   output logic aux_level_3v3,
   // phase synchronisation
   output logic phase_sync_pulse,
   output logic [23:0] phase_value,
   // oscillator controls
   output logic manual_cal_en,
   output logic [4:0] cap_switch,
   output logic [2:0] subband,
   output logic manual_tune_en,
   output logic charge_pump_scale_en,
   // divider and gains
   output logic rf_mute,
   output logic [5:0] rf_divide,
   output logic [1:0] mix_carrier_output_gain,
   output logic [1:0] second_carrier_output_gain,
   output logic divider_stage_gain
);
   logic [23:0] auxiliary_output_control; // aux port setup
   logic [23:0] manual_oscillator_config; // manual calibration setup
   logic [23:0] gain_and_divider; // divide ratio and gains
   logic chip_en_meta; // first sync stage
   logic chip_en_sync; // second sync stage
   logic chip_en_last; // for edge detection
   logic [5:0] next_divide; // effective divide ratio
   logic [5:0] divide_field; // raw divide field

   aux_cfg_if aux_cfg ();

   // ==========================================================
   // register writes; reserved bits stored as written
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         auxiliary_output_control <= vco_ctrl_pkg::aux_out_ctrl_reset;
         manual_oscillator_config <= vco_ctrl_pkg::manual_osc_cfg_reset;
         gain_and_divider <= vco_ctrl_pkg::gain_div_reset;
      end else if (reg_wr) begin
         // host keeps reserved fields at reset values
         case (reg_addr) // RL16
            vco_ctrl_pkg::aux_out_ctrl_addr: auxiliary_output_control <= reg_wdata;
            vco_ctrl_pkg::manual_osc_cfg_addr: manual_oscillator_config <= reg_wdata;
            vco_ctrl_pkg::gain_div_addr: gain_and_divider <= reg_wdata;
            default: ; // unmapped writes ignored
         endcase
      end
   end

   // ==========================================================
   // register reads, answered one cycle later
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         reg_rdata <= 24'h000000;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= reg_rd;
         if (reg_rd) begin
            case (reg_addr)
               vco_ctrl_pkg::aux_out_ctrl_addr: reg_rdata <= auxiliary_output_control;
               vco_ctrl_pkg::manual_osc_cfg_addr: reg_rdata <= manual_oscillator_config;
               vco_ctrl_pkg::gain_div_addr: reg_rdata <= gain_and_divider;
               default: reg_rdata <= 24'h000000; // unmapped reads zero
            endcase
         end
      end
   end

   // ==========================================================
   // chip enable pin synchroniser
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         chip_en_meta <= 1'b0;
         chip_en_sync <= 1'b0;
         chip_en_last <= 1'b0;
      end else begin
         chip_en_meta <= chip_en_pin;
         chip_en_sync <= chip_en_meta;
         chip_en_last <= chip_en_sync;
      end
   end

   // ==========================================================
   // phase sync trigger on rising chip enable
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         phase_sync_pulse <= 1'b0;
         phase_value <= 24'h000000;
      end else begin
         phase_sync_pulse <= 1'b0;
         if (chip_en_sync && !chip_en_last && exact_freq_mode
             && auxiliary_output_control[vco_ctrl_pkg::phase_sync_bit]) begin // RL4
            phase_sync_pulse <= 1'b1;
            // phase = 2 pi * seed / 2^24
            phase_value <= phase_seed; // RL15
         end
      end
   end

   // ==========================================================
   // auxiliary driver configuration
   assign aux_cfg.serial_mode = auxiliary_output_control[vco_ctrl_pkg::aux_serial_mode_bit];
   assign aux_cfg.static_value = auxiliary_output_control[vco_ctrl_pkg::aux_value_lsb +: 3];
   assign aux_cfg.route = auxiliary_output_control[vco_ctrl_pkg::aux_route_lsb +: 2];
   assign aux_cfg.idle = vco_ctrl_pkg::aux_idle_type'(
      auxiliary_output_control[vco_ctrl_pkg::aux_idle_lsb +: 2]);
   assign aux_cfg.serial_bits = aux_serial_bits;
   assign aux_cfg.status = status_in;
   assign aux_cfg.enable = aux_enable;

   // pin drive of the three auxiliary outputs
   aux_output_driver u_aux (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .cfg(aux_cfg.driver),
      .aux_out(aux_out),
      .aux_oe_n(aux_oe_n)
   );

   // ==========================================================
   // divide ratio decode
   assign divide_field = gain_and_divider[vco_ctrl_pkg::divide_lsb +: 6];
   always_comb begin
      if (divide_field > vco_ctrl_pkg::divide_max) begin
         next_divide = vco_ctrl_pkg::divide_max; // RL11
      end else if (divide_field <= 6'h02) begin
         next_divide = divide_field; // mute, fundamental or 2
      end else begin
         next_divide = {divide_field[5:1], 1'b0}; // RL11
      end
   end

   // ==========================================================
   // auxiliary level select output
   // plain copy of the bit; the pad supply switch itself sits outside
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         aux_level_3v3 <= vco_ctrl_pkg::aux_out_ctrl_reset[vco_ctrl_pkg::aux_level_bit];
      end else begin
         aux_level_3v3 <= auxiliary_output_control[vco_ctrl_pkg::aux_level_bit]; // RL3
      end
   end

   // ==========================================================
   // oscillator control outputs
   // reset values come from the register reset word so the two never drift
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         manual_cal_en <= vco_ctrl_pkg::manual_osc_cfg_reset[vco_ctrl_pkg::manual_cal_bit];
         cap_switch <= vco_ctrl_pkg::manual_osc_cfg_reset[vco_ctrl_pkg::cap_switch_lsb +: 5];
         subband <= vco_ctrl_pkg::manual_osc_cfg_reset[vco_ctrl_pkg::subband_lsb +: 3];
         manual_tune_en <= vco_ctrl_pkg::manual_osc_cfg_reset[vco_ctrl_pkg::manual_tune_bit];
         charge_pump_scale_en <=
            vco_ctrl_pkg::manual_osc_cfg_reset[vco_ctrl_pkg::charge_pump_scale_bit];
      end else begin
         manual_cal_en <= manual_oscillator_config[vco_ctrl_pkg::manual_cal_bit]; // RL7
         cap_switch <= manual_oscillator_config[vco_ctrl_pkg::cap_switch_lsb +: 5]; // RL8
         subband <= manual_oscillator_config[vco_ctrl_pkg::subband_lsb +: 3]; // RL8
         manual_tune_en <= manual_oscillator_config[vco_ctrl_pkg::manual_tune_bit]; // RL9
         charge_pump_scale_en <=
            manual_oscillator_config[vco_ctrl_pkg::charge_pump_scale_bit]; // RL10
      end
   end

   // ==========================================================
   // divider and gain outputs
   // the reset divide ratio is a valid one, so raw and decoded agree at reset
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         rf_mute <= (vco_ctrl_pkg::gain_div_reset[vco_ctrl_pkg::divide_lsb +: 6] == 6'h00);
         rf_divide <= vco_ctrl_pkg::gain_div_reset[vco_ctrl_pkg::divide_lsb +: 6];
         mix_carrier_output_gain <=
            vco_ctrl_pkg::gain_div_reset[vco_ctrl_pkg::carrier_gain_lsb +: 2];
         second_carrier_output_gain <=
            vco_ctrl_pkg::gain_div_reset[vco_ctrl_pkg::second_gain_lsb +: 2];
         divider_stage_gain <= vco_ctrl_pkg::gain_div_reset[vco_ctrl_pkg::divider_gain_bit];
      end else begin
         rf_mute <= (divide_field == 6'h00); // RL11
         rf_divide <= next_divide;
         mix_carrier_output_gain <=
            gain_and_divider[vco_ctrl_pkg::carrier_gain_lsb +: 2]; // RL12
         second_carrier_output_gain <=
            gain_and_divider[vco_ctrl_pkg::second_gain_lsb +: 2]; // RL13
         divider_stage_gain <= gain_and_divider[vco_ctrl_pkg::divider_gain_bit]; // RL14
      end
   end
endmodule

// ---- hdl/vco_ctrl_pkg.sv ----
// constants for the vco subsystem control register bank
// assumes 24-bit registers reached by word index on the register port
package vco_ctrl_pkg;
   // ==========================================================
   // register indices
   localparam logic [5:0] aux_out_ctrl_addr = 6'h14;
   localparam logic [5:0] manual_osc_cfg_addr = 6'h15;
   localparam logic [5:0] gain_div_addr = 6'h16;
   localparam int reg_width = 24;
   // ==========================================================
   // reset values
   localparam logic [23:0] aux_out_ctrl_reset = 24'h000220;
   localparam logic [23:0] manual_osc_cfg_reset = 24'h0F48A0;
   localparam logic [23:0] gain_div_reset = 24'h0006C1;
   // ==========================================================
   // auxiliary output control fields
   localparam int aux_serial_mode_bit = 0;
   localparam int aux_value_lsb = 1;
   localparam int aux_level_bit = 4;
   localparam int phase_sync_bit = 9;
   localparam int aux_route_lsb = 10;
   localparam int aux_idle_lsb = 12;
   // ==========================================================
   // manual oscillator config fields
   localparam int manual_cal_bit = 0;
   localparam int cap_switch_lsb = 1;
   localparam int subband_lsb = 6;
   localparam int manual_tune_bit = 9;
   localparam int charge_pump_scale_bit = 16;
   // ==========================================================
   // gain and divider fields
   localparam int divide_lsb = 0;
   localparam int carrier_gain_lsb = 6;
   localparam int second_gain_lsb = 8;
   localparam int divider_gain_bit = 10;
   localparam logic [5:0] divide_max = 6'h3E;
   // ==========================================================
   // idle drive of disabled auxiliary outputs
   typedef enum logic [1:0] {
      idle_hiz,
      idle_driven,
      idle_high,
      idle_low
   } aux_idle_type;
endpackage

// ---- hdl/aux_cfg_if.sv ----
// carrier between the register bank and the auxiliary output driver
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface aux_cfg_if;
   logic serial_mode; // 1: serial port, 0: static outputs
   logic [2:0] static_value; // static output values
   logic [1:0] route; // status routing, 0 none
   vco_ctrl_pkg::aux_idle_type idle; // drive state while disabled
   logic [2:0] serial_bits; // serial port signals
   logic status; // multiplexed status level
   logic enable; // auxiliary port enabled
   modport bank (output serial_mode, static_value, route, idle, serial_bits, status, enable);
   modport driver (input serial_mode, static_value, route, idle, serial_bits, status, enable);
endinterface

// ---- hdl/aux_output_driver.sv ----
// registered drive of the three auxiliary outputs
// assumes configuration from the register bank on the same clock
`timescale 1ns/1ps
module aux_output_driver (
   // clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // configuration
   aux_cfg_if.driver cfg,
   // pins, oe low while driving
   output logic [2:0] aux_out,
   output logic [2:0] aux_oe_n
);
   logic [2:0] next_out; // chosen levels
   logic [2:0] next_oe_n; // chosen enables

   // ==========================================================
   // output selection per pin
   genvar i;
   generate
      for (i = 0; i < 3; i++) begin : g_pin
         always_comb begin
            if (!cfg.enable) begin
               // disabled: idle drive state
               case (cfg.idle)
                  vco_ctrl_pkg::idle_hiz: begin
                     next_out[i] = 1'b0;
                     next_oe_n[i] = 1'b1; // RL6
                  end
                  vco_ctrl_pkg::idle_driven: begin
                     next_out[i] = cfg.serial_mode ? cfg.serial_bits[i] : cfg.static_value[i];
                     next_oe_n[i] = 1'b0; // RL6
                  end
                  vco_ctrl_pkg::idle_high: begin
                     next_out[i] = 1'b1; // RL6
                     next_oe_n[i] = 1'b0;
                  end
                  default: begin
                     next_out[i] = 1'b0; // RL6
                     next_oe_n[i] = 1'b0;
                  end
               endcase
            end else if (cfg.route == 2'(i + 1)) begin
               // status replaces this pin
               next_out[i] = cfg.status; // RL5
               next_oe_n[i] = 1'b0;
            end else if (cfg.serial_mode) begin
               next_out[i] = cfg.serial_bits[i]; // RL1
               next_oe_n[i] = 1'b0;
            end else begin
               next_out[i] = cfg.static_value[i]; // RL2
               next_oe_n[i] = 1'b0;
            end
         end
      end
   endgenerate

   // ==========================================================
   // pin registers, high impedance after reset
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         aux_out <= 3'h0;
         aux_oe_n <= 3'h7;
      end else begin
         aux_out <= next_out;
         aux_oe_n <= next_oe_n;
      end
   end
endmodule

// ---- dv/vco_regs_checker.sv ----
// concurrent checks on the vco control register bank ports
// assumes binding onto the bank top module, one clock domain
`timescale 1ns/1ps
module vco_regs_checker (
   // clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // register port
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [5:0] reg_addr,
   input wire logic [23:0] reg_wdata,
   input wire logic reg_rvalid,
   // observed context and outputs
   input wire logic [23:0] phase_seed,
   input wire logic phase_sync_pulse,
   input wire logic [23:0] phase_value,
   input wire logic aux_level_3v3,
   input wire logic [4:0] cap_switch,
   input wire logic rf_mute,
   input wire logic [5:0] rf_divide,
   input wire logic [1:0] mix_carrier_output_gain,
   input wire logic [1:0] second_carrier_output_gain,
   input wire logic divider_stage_gain
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   // ==========================================================
   // write decode per register
   wire w14 = reg_wr && reg_addr == vco_ctrl_pkg::aux_out_ctrl_addr;
   wire w15 = reg_wr && reg_addr == vco_ctrl_pkg::manual_osc_cfg_addr;
   wire w16 = reg_wr && reg_addr == vco_ctrl_pkg::gain_div_addr;
   wire [4:0] gains = {divider_stage_gain, second_carrier_output_gain, mix_carrier_output_gain};
   // ==========================================================
   // assertions
   a_rvalid_follows: assert property (reg_rd |=> reg_rvalid)
      else $error("read strobe without valid");
   a_rvalid_cause: assert property (reg_rvalid |-> $past(reg_rd))
      else $error("valid without read");
   a_divide_mute: assert property (w16 && reg_wdata[5:0] == 6'h00 |-> ##2 rf_mute)
      else $error("divide zero did not mute");
   a_divide_one: assert property (w16 && reg_wdata[5:0] == 6'h01 |->
      ##2 rf_divide == 6'h01)
      else $error("fundamental ratio wrong");
   a_divide_even: assert property (w16 && reg_wdata[5:0] > 6'h01 |->
      ##2 !rf_mute && rf_divide == ($past(reg_wdata[5:0], 2) & 6'h3E))
      else $error("divide ratio wrong");
   a_cap_follow: assert property (w15 |-> ##2 cap_switch == $past(reg_wdata[5:1], 2))
      else $error("capacitor setting wrong");
   a_gain_follow: assert property (w16 |->
      ##2 gains == $past(reg_wdata[10:6], 2))
      else $error("gain fields wrong");
   a_level_follow: assert property (w14 |-> ##2 aux_level_3v3 == $past(reg_wdata[4], 2))
      else $error("level bit wrong");
   a_sync_single: assert property (phase_sync_pulse |=> !phase_sync_pulse)
      else $error("sync pulse too long");
   a_sync_value: assert property (phase_sync_pulse |-> phase_value == $past(phase_seed))
      else $error("phase value not seed");
   // main scenarios
   c_sync: cover property (phase_sync_pulse);
   c_mute: cover property (w16 && reg_wdata[5:0] == 6'h00);
   c_read: cover property (reg_rvalid);
endmodule
bind vco_subsystem_control_regs vco_regs_checker chk (.sys_clk, .nrst, .reg_wr, .reg_rd,
   .reg_addr, .reg_wdata, .reg_rvalid, .phase_seed, .phase_sync_pulse, .phase_value,
   .aux_level_3v3, .cap_switch, .rf_mute, .rf_divide, .mix_carrier_output_gain,
   .second_carrier_output_gain, .divider_stage_gain);

// ---- dv/host_model.sv ----
// host controller model driving the register strobe port
// assumes one-cycle strobes and read answer one edge later
`timescale 1ns/1ps
module host_model (
   // clock
   input wire logic sys_clk,
   // register port
   output logic reg_wr,
   output logic reg_rd,
   output logic [5:0] reg_addr,
   output logic [23:0] reg_wdata,
   input wire logic [23:0] reg_rdata,
   input wire logic reg_rvalid
);
   // idle bus at time zero
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 6'h3F;
      reg_wdata = 24'h000000;
   end
   // one write, lines inverted once released
   task wr(input logic [5:0] a, input logic [23:0] d);
      @(posedge sys_clk);
      #1;
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(posedge sys_clk);
      #1;
      reg_wr = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask
   // one read, data taken while valid stands
   task rd(input logic [5:0] a, output logic [23:0] d);
      @(posedge sys_clk);
      #1;
      reg_addr = a;
      reg_rd = 1'b1;
      @(posedge sys_clk);
      #1;
      reg_rd = 1'b0;
      reg_addr = ~a;
      d = (reg_rvalid === 1'b1) ? reg_rdata : 24'hXXXXXX;
   endtask
endmodule

// ---- dv/test_vco_subsystem_control_regs.sv ----
// self-checking bench for the vco control register bank
// assumes the host model drives the register port
`timescale 1ns/1ps
module test_vco_subsystem_control_regs;
   logic sys_clk, nrst, chip_en_pin, exact_freq_mode, status_in, aux_enable, reg_wr, reg_rd;
   logic reg_rvalid, aux_level_3v3, phase_sync_pulse, manual_cal_en, manual_tune_en;
   logic charge_pump_scale_en, rf_mute, divider_stage_gain, hit;
   logic [1:0] mix_carrier_output_gain, second_carrier_output_gain;
   logic [2:0] aux_serial_bits, aux_out, aux_oe_n, subband;
   logic [4:0] cap_switch;
   logic [5:0] reg_addr, rf_divide, n;
   logic [10:0] f;
   logic [23:0] reg_wdata, reg_rdata, phase_seed, phase_value, rd_data;
   logic [5:0] idle_exp [4] = '{6'b111000, 6'b000110, 6'b000111, 6'b000000};
   int n_fail = 0;
   int check_count = 0;
   host_model host (.sys_clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid);
   vco_subsystem_control_regs dut (.sys_clk, .nrst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
      .reg_rdata, .reg_rvalid, .chip_en_pin, .exact_freq_mode, .phase_seed, .status_in,
      .aux_enable, .aux_serial_bits, .aux_out, .aux_oe_n, .aux_level_3v3, .phase_sync_pulse,
      .phase_value, .manual_cal_en, .cap_switch, .subband, .manual_tune_en,
      .charge_pump_scale_en, .rf_mute, .rf_divide, .mix_carrier_output_gain,
      .second_carrier_output_gain, .divider_stage_gain);
   // ==========================================================
   // helpers
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   task chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task tick(input int k);
      repeat (k) @(posedge sys_clk);
      #1;
   endtask
   task rdchk(input logic [5:0] a, input logic [23:0] e);
      host.rd(a, rd_data);
      chk("rdata", rd_data, e);
   endtask
   // auxiliary word, reserved bits kept at reset value
   function automatic logic [23:0] aw(logic [1:0] idle, logic [1:0] rt, logic sy, logic lv,
      logic [2:0] v, logic md);
      return {10'h000, idle, rt, sy, 4'h1, lv, v, md};
   endfunction
   task auxchk(input logic [23:0] w, input logic [5:0] e);
      host.wr(vco_ctrl_pkg::aux_out_ctrl_addr, w);
      tick(3);
      chk("aux pins", {aux_oe_n, aux_oe_n == 3'b111 ? 3'b000 : aux_out}, e);
   endtask
   task sync(input logic e);
      chip_en_pin = 1'b1;
      hit = 1'b0;
      repeat (8) begin
         tick(1);
         if (phase_sync_pulse === 1'b1) hit = 1'b1;
         if (phase_sync_pulse === 1'b1) chk("phase", phase_value, phase_seed);
      end
      chk("sync", hit, e);
      chip_en_pin = 1'b0;
      tick(4);
   endtask
   task summarize();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // watchdog
   initial begin
      #500000;
      n_fail++;
      summarize();
   end
   // ==========================================================
   // main sequence
   initial begin
      {nrst, chip_en_pin, exact_freq_mode, status_in, aux_serial_bits} = 7'h00;
      {aux_enable, phase_seed} = {1'b1, 24'h5A3C96};
      tick(3);
      nrst = 1'b1;
      chk("divide", rf_divide, 24'h1);
      chk("gains", {mix_carrier_output_gain, second_carrier_output_gain, divider_stage_gain},
         24'h1D);
      chk("osc", {charge_pump_scale_en, manual_tune_en, subband, cap_switch, manual_cal_en},
         24'h4A0);
      rdchk(vco_ctrl_pkg::aux_out_ctrl_addr, vco_ctrl_pkg::aux_out_ctrl_reset);
      rdchk(vco_ctrl_pkg::manual_osc_cfg_addr, 24'h0F48A0);
      rdchk(vco_ctrl_pkg::gain_div_addr, 24'h0006C1);
      rdchk(6'h17, 24'h0);
      for (int a = 20; a < 23; a++) host.wr(6'(a), 24'hFFFFFF);
      host.wr(6'h20, 24'h0);
      for (int a = 20; a < 23; a++) rdchk(6'(a), 24'hFFFFFF);
      for (int i = 0; i < 2; i++) begin
         f = i ? 11'h2AA : 11'h555;
         host.wr(vco_ctrl_pkg::manual_osc_cfg_addr, {7'h07, f[10], 6'h12, f[9:0]});
         tick(2);
         chk("osc", {charge_pump_scale_en, manual_tune_en, subband, cap_switch, manual_cal_en},
            f);
      end
      for (int i = 0; i < 64; i++) begin
         n = 6'(i);
         host.wr(vco_ctrl_pkg::gain_div_addr, {13'h0, 5'b11101, n});
         tick(2);
         chk("mute", rf_mute, n == 6'h00);
         if (n != 6'h00) chk("divide", rf_divide, n == 6'h01 ? 6'h01 : n & 6'h3E);
      end
      for (int g = 0; g < 4; g++) begin
         host.wr(vco_ctrl_pkg::gain_div_addr, {13'h0, 1'(g), ~2'(g), 2'(g), 6'h04});
         tick(2);
         chk("gains", {mix_carrier_output_gain, second_carrier_output_gain, divider_stage_gain},
            {2'(g), ~2'(g), 1'(g)});
      end
      auxchk(aw(0, 0, 1, 1, 3'b101, 0), 6'b000101);
      chk("level", aux_level_3v3, 1'b1);
      aux_serial_bits = 3'b011;
      auxchk(aw(0, 0, 1, 0, 3'b101, 1), 6'b000011);
      chk("level", aux_level_3v3, 1'b0);
      status_in = 1'b1;
      for (int r = 1; r < 4; r++) auxchk(aw(2'(r), 2'(r), 1, 0, 0, 0), 6'(1 << (r - 1)));
      aux_enable = 1'b0;
      for (int k = 0; k < 4; k++) auxchk(aw(2'(k), 0, 1, 0, 3'b110, 0), idle_exp[k]);
      aux_enable = 1'b1;
      exact_freq_mode = 1'b1;
      sync(1'b1);
      exact_freq_mode = 1'b0;
      sync(1'b0);
      exact_freq_mode = 1'b1;
      host.wr(vco_ctrl_pkg::aux_out_ctrl_addr, aw(0, 0, 0, 0, 0, 0));
      tick(3);
      sync(1'b0);
      // reset in mid-run brings registers and outputs back
      nrst = 1'b0;
      tick(1);
      nrst = 1'b1;
      rdchk(vco_ctrl_pkg::gain_div_addr, vco_ctrl_pkg::gain_div_reset);
      chk("divide", rf_divide, 24'h1);
      summarize();
   end
endmodule
